// ### rtl/nps_map.vh
// Constants for the host-side command sequencer of the 16-bit erasable memory.
// Assumes a 200 MHz sys_clk; included by bare name from the rtl modules.
`ifndef NPS_MAP_VH
`define NPS_MAP_VH

// Command addresses (word addresses)
`define NPS_ADDR_UNLOCK1   21'h000555
`define NPS_ADDR_UNLOCK2   21'h0002aa
`define NPS_ADDR_ID_MFR    21'h000000
`define NPS_ADDR_ID_DEV    21'h000001
// Command data words
`define NPS_DAT_UNLOCK1    16'h00aa
`define NPS_DAT_UNLOCK2    16'h0055
`define NPS_DAT_PROG       16'h00a0
`define NPS_DAT_ERASE      16'h0080
`define NPS_DAT_CHIP       16'h0010
`define NPS_DAT_ID         16'h0090
`define NPS_DAT_RESET      16'h00f0
// Status bit positions
`define NPS_POLL_BIT       7
`define NPS_TOGGLE_BIT     6
`define NPS_TIMEOUT_BIT    5
// User opcodes
`define NPS_OP_READ        3'h0
`define NPS_OP_PROG        3'h1
`define NPS_OP_ERASE       3'h2
`define NPS_OP_ID          3'h3
`define NPS_OP_RESET       3'h4
`define NPS_OP_ACCPROG     3'h5
// Bus phase timing: at least 60 ns per strobe phase at 5 ns per cycle
`define NPS_PHASE_NS       60
`define NPS_CLK_NS         5
`define NPS_PHASE_CYC      ((`NPS_PHASE_NS + `NPS_CLK_NS - 1) / `NPS_CLK_NS)
`define NPS_CNT_W          4
// Strobe step codes
`define NPS_STEP_SETUP     2'h0
`define NPS_STEP_STROBE    2'h1
`define NPS_STEP_HOLD      2'h2
`define NPS_STEP_W         2

`endif

// ### rtl/nps_bus_cycle.v
// One asynchronous bus cycle (write or read) on the memory pins.
// Assumes the caller holds addr/data/write stable from start until done.
`timescale 1ns/100ps
`include "nps_map.vh"
module nps_bus_cycle (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        start,     // One-cycle request
   input  wire        isWrite,   // 1 write, 0 read
   input  wire [15:0] pinDataIn, // Synchronised data bus
   output reg         chipSel_n, // Chip select
   output reg         writeEn_n, // Write strobe
   output reg         outEn_n,   // Output enable
   output reg         dataOe,    // High while the host drives data
   output reg  [15:0] readData,  // Captured read word
   output reg         done       // One-cycle completion pulse
);
   reg [`NPS_STEP_W-1:0] step;    // Setup, strobe, hold
   reg [`NPS_CNT_W-1:0]  cnt;     // Cycles left in the phase
   reg                   active;  // Cycle under way
   reg                   wr;      // Latched direction
   // Phase count cut to the counter width on purpose; the count fits in it
   localparam [31:0]           PHASE_FULL = `NPS_PHASE_CYC;
   localparam [`NPS_CNT_W-1:0] PHASE_LOAD = PHASE_FULL[`NPS_CNT_W-1:0];

   // Each phase lasts one cycle more than the phase count, 65 ns at 5 ns per cycle, so the device sees clean edges
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         step      <= `NPS_STEP_SETUP;
         cnt       <= {`NPS_CNT_W{1'b0}};
         active    <= 1'b0;
         wr        <= 1'b0;
         chipSel_n <= 1'b1;
         writeEn_n <= 1'b1;
         outEn_n   <= 1'b1;
         dataOe    <= 1'b0;
         readData  <= 16'h0000;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!active) begin
            if (start) begin // Setup: address and select first, strobe later
               active    <= 1'b1;
               wr        <= isWrite;
               step      <= `NPS_STEP_SETUP;
               cnt       <= PHASE_LOAD;
               chipSel_n <= 1'b0;
               dataOe    <= isWrite;
            end
         end else if (cnt != {`NPS_CNT_W{1'b0}}) begin
            cnt <= cnt - 1'b1;
         end else begin
            case (step)
               `NPS_STEP_SETUP: begin // Falling strobe latches the address
                  step      <= `NPS_STEP_STROBE;
                  cnt       <= PHASE_LOAD;
                  writeEn_n <= ~wr;
                  outEn_n   <= wr;
               end
               `NPS_STEP_STROBE: begin // Rising write strobe latches data
                  step      <= `NPS_STEP_HOLD;
                  cnt       <= PHASE_LOAD;
                  writeEn_n <= 1'b1;
                  outEn_n   <= 1'b1;
                  if (!wr)
                     readData <= pinDataIn;
               end
               default: begin // Release the bus
                  active    <= 1'b0;
                  chipSel_n <= 1'b1;
                  dataOe    <= 1'b0;
                  done      <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // nps_bus_cycle

// ### rtl/nps_host_sequencer.v
// Host-side sequencer that issues program, erase, identify and reset
// command sequences to the 16-bit memory and polls status bits.
// Assumes the memory pins are wired directly; data bus split in/out/enable.
//
// Function
// - Program: two unlocks, setup, address/data
// - Reset pin aborts; host reissues program (abortReq is taken only in idle, so no program is cut short)
// - Accel level only during accelerated program
// - Erase: unlock, 80, unlock, 10
// - Reset pin aborts erase; reissue (abortReq is taken only in idle, so no erase is cut short)
// - Poll the programmed address
// - After timeout host writes reset command
// - Address on falling, data rising strobe
`timescale 1ns/100ps
`include "nps_map.vh"
module nps_host_sequencer (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        cmdValid,     // One-cycle command request
   input  wire [2:0]  cmdOp,        // Operation code
   input  wire [20:0] cmdAddr,      // Word address for read/program
   input  wire [15:0] cmdData,      // Program data
   input  wire        abortReq,     // Pulse the device reset pin
   input  wire [15:0] memDataIn,    // Data bus from pins
   output reg         cmdReady,     // Idle, accepts a command
   output reg         cmdDone,      // One-cycle completion pulse
   output reg         cmdFail,      // Timeout flag seen or poll bit mismatch at the end, with cmdDone
   output reg  [15:0] rdData,       // Read or ID result
   output reg  [20:0] memAddr,      // Address pins
   output reg  [15:0] memDataOut,   // Data bus drive value
   output reg         memDataOe,    // Data bus driven
   output reg         memChipSel_n, // Chip select
   output reg         memWriteEn_n, // Write strobe
   output reg         memOutEn_n,   // Output enable
   output reg         memReset_n,   // Hardware reset pin
   output reg         accelHigh     // Drive the accelerate pin to the high level
);
   localparam ST_IDLE  = 3'h0; // Waiting for a command
   localparam ST_WR    = 3'h1; // Issuing write cycles
   localparam ST_POLL  = 3'h2; // Status polling reads
   localparam ST_READ  = 3'h3; // Single data read
   localparam ST_ABORT = 3'h4; // Holding the reset pin
   // Reset pin count cut to the counter width on purpose; the count fits in it
   localparam [31:0]           PHASE_FULL = `NPS_PHASE_CYC;
   localparam [`NPS_CNT_W-1:0] PHASE_LOAD = PHASE_FULL[`NPS_CNT_W-1:0];

   reg [15:0] dSync1;            // First sync stage, read only by dSync2
   reg [15:0] dSync2;            // Second sync stage
   reg [2:0]  state;             // Main state
   reg [2:0]  op;                // Latched operation
   reg [2:0]  idx;               // Write cycle index
   reg [20:0] tgtAddr;           // Latched target address
   reg [15:0] tgtData;           // Latched program data
   reg        busStart;          // Start one bus cycle
   reg        busWrite;          // Direction of that cycle
   reg        havePrev;          // A previous poll read exists
   reg        prevToggle;        // Toggle bit of the previous poll read
   reg        prevTimeout;       // Timeout bit of the previous poll read
   reg [`NPS_CNT_W-1:0] rstCnt;  // Reset pin low time
   wire        busDone;          // Bus cycle complete
   wire [15:0] busRead;          // Bus cycle read word
   wire        cycChipSel_n;
   wire        cycWriteEn_n;
   wire        cycOutEn_n;
   wire        cycDataOe;

   // Number of write cycles for an operation
   function [2:0] seqLen;
      input [2:0] o;
      begin
         case (o)
            `NPS_OP_PROG:    seqLen = 3'h4;
            `NPS_OP_ACCPROG: seqLen = 3'h2;
            `NPS_OP_ERASE:   seqLen = 3'h6;
            `NPS_OP_ID:      seqLen = 3'h3;
            default:         seqLen = 3'h1; // Reset command alone
         endcase
      end
   endfunction

   // Address and data of write cycle i of operation o
   function [36:0] seqWord;
      input [2:0]  o;
      input [2:0]  i;
      input [20:0] a;
      input [15:0] d;
      reg   [2:0]  j;
      begin
         j = (o == `NPS_OP_ACCPROG) ? i + 3'h2 : i; // unlocks skipped
         case (j)
            3'h0: seqWord = {`NPS_ADDR_UNLOCK1, `NPS_DAT_UNLOCK1};
            3'h1: seqWord = {`NPS_ADDR_UNLOCK2, `NPS_DAT_UNLOCK2};
            3'h2: seqWord = {`NPS_ADDR_UNLOCK1,
                             (o == `NPS_OP_ERASE) ? `NPS_DAT_ERASE :
                             (o == `NPS_OP_ID) ? `NPS_DAT_ID : `NPS_DAT_PROG};
            3'h3: seqWord = (o == `NPS_OP_ERASE) ? {`NPS_ADDR_UNLOCK1, `NPS_DAT_UNLOCK1}
                                                  : {a, d}; // Program address and data
            3'h4: seqWord = {`NPS_ADDR_UNLOCK2, `NPS_DAT_UNLOCK2};
            default: seqWord = {`NPS_ADDR_UNLOCK1, `NPS_DAT_CHIP};
         endcase
         if (o == `NPS_OP_RESET)
            seqWord = {a, `NPS_DAT_RESET}; // Any address takes the reset command
      end
   endfunction

   nps_bus_cycle uCycle (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .start     (busStart),
      .isWrite   (busWrite),
      .pinDataIn (dSync2),
      .chipSel_n (cycChipSel_n),
      .writeEn_n (cycWriteEn_n),
      .outEn_n   (cycOutEn_n),
      .dataOe    (cycDataOe),
      .readData  (busRead),
      .done      (busDone)
   );

   // Data pins come from another domain; two flops before use
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dSync1 <= 16'h0000;
         dSync2 <= 16'h0000;
      end else begin
         dSync1 <= memDataIn;
         dSync2 <= dSync1;
      end
   end

   // Strobes re-registered so every top output is a flop
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         memChipSel_n <= 1'b1;
         memWriteEn_n <= 1'b1;
         memOutEn_n   <= 1'b1;
         memDataOe    <= 1'b0;
      end else begin
         memChipSel_n <= cycChipSel_n;
         memWriteEn_n <= cycWriteEn_n;
         memOutEn_n   <= cycOutEn_n;
         memDataOe    <= cycDataOe;
      end
   end

   // Main command sequencer
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state      <= ST_IDLE;
         op         <= `NPS_OP_READ;
         idx        <= 3'h0;
         tgtAddr    <= 21'h000000;
         tgtData    <= 16'h0000;
         busStart   <= 1'b0;
         busWrite   <= 1'b0;
         havePrev   <= 1'b0;
         prevToggle <= 1'b0;
         prevTimeout <= 1'b0;
         rstCnt     <= {`NPS_CNT_W{1'b0}};
         cmdReady   <= 1'b1;
         cmdDone    <= 1'b0;
         cmdFail    <= 1'b0;
         rdData     <= 16'h0000;
         memAddr    <= 21'h000000;
         memDataOut <= 16'h0000;
         memReset_n <= 1'b1;
         accelHigh  <= 1'b0;
      end else begin
         busStart <= 1'b0;
         cmdDone  <= 1'b0;
         case (state)
            ST_IDLE: begin
               cmdReady <= 1'b1;
               if (abortReq) begin // Pin reset taken only here in idle, never during an operation
                  state      <= ST_ABORT;
                  cmdReady   <= 1'b0;
                  memReset_n <= 1'b0;
                  rstCnt     <= PHASE_LOAD;
               end else if (cmdValid) begin
                  op       <= cmdOp;
                  tgtAddr  <= cmdAddr;
                  tgtData  <= cmdData;
                  cmdReady <= 1'b0;
                  cmdFail  <= 1'b0;
                  idx      <= 3'h0;
                  havePrev <= 1'b0;
                  prevTimeout <= 1'b0;
                  // Accel level raised only for accelerated program
                  accelHigh <= (cmdOp == `NPS_OP_ACCPROG);
                  if (cmdOp == `NPS_OP_READ) begin
                     state    <= ST_READ;
                     memAddr  <= cmdAddr;
                     busWrite <= 1'b0;
                     busStart <= 1'b1;
                  end else begin
                     state <= ST_WR;
                     {memAddr, memDataOut} <= seqWord(cmdOp, 3'h0, cmdAddr, cmdData);
                     busWrite <= 1'b1;
                     busStart <= 1'b1;
                  end
               end
            end
            ST_WR: if (busDone) begin
               if (idx + 3'h1 < seqLen(op)) begin // Cycles in fixed order
                  idx      <= idx + 3'h1;
                  {memAddr, memDataOut} <= seqWord(op, idx + 3'h1, tgtAddr, tgtData);
                  busStart <= 1'b1;
               end else if (op == `NPS_OP_ID || op == `NPS_OP_RESET) begin
                  state   <= ST_READ; // ID mode: read code at given address
                  memAddr <= (op == `NPS_OP_ID) ? tgtAddr : memAddr;
                  busWrite <= 1'b0;
                  busStart <= 1'b1;
               end else begin
                  // Polling begins only after the last write strobe rose
                  state    <= ST_POLL;
                  memAddr  <= (op == `NPS_OP_ERASE) ? memAddr : tgtAddr;
                  busWrite <= 1'b0;
                  busStart <= 1'b1;
               end
            end
            ST_POLL: if (busDone) begin
               havePrev   <= 1'b1;
               prevToggle <= busRead[`NPS_TOGGLE_BIT];
               prevTimeout <= busRead[`NPS_TIMEOUT_BIT];
               // Device runs its own algorithm; host only reads
               if (havePrev && busRead[`NPS_TOGGLE_BIT] == prevToggle) begin
                  // Toggle stopped: device back in array read
                  state     <= ST_IDLE;
                  accelHigh <= 1'b0;
                  cmdDone   <= 1'b1;
                  rdData    <= busRead;
                  // Poll bit true value / erase gives 1 0->1 not possible
                  cmdFail   <= (op == `NPS_OP_ERASE) ? ~busRead[`NPS_POLL_BIT]
                                : (busRead[`NPS_POLL_BIT] != tgtData[`NPS_POLL_BIT]);
               end else if (busRead[`NPS_TIMEOUT_BIT] && prevTimeout && havePrev) begin
                  // Bit 5 on two status reads in a row: a finished word whose own
                  // bit 5 is set must not pass for a timeout
                  // Timeout: issue reset command before anything else
                  state     <= ST_WR;
                  op        <= `NPS_OP_RESET;
                  idx       <= 3'h0;
                  cmdFail   <= 1'b1;
                  accelHigh <= 1'b0;
                  memDataOut <= `NPS_DAT_RESET;
                  busWrite  <= 1'b1;
                  busStart  <= 1'b1;
               end else begin
                  busStart <= 1'b1; // Device ignores writes now
               end
            end
            ST_READ: if (busDone) begin
               state   <= ST_IDLE;
               rdData  <= busRead;
               cmdDone <= 1'b1;
            end
            ST_ABORT: begin // Hold the reset pin, then restart clean
               accelHigh <= 1'b0;
               if (rstCnt != {`NPS_CNT_W{1'b0}}) begin
                  rstCnt <= rstCnt - 1'b1;
               end else begin
                  memReset_n <= 1'b1;
                  state      <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // nps_host_sequencer

// ### testbench/nps_mem_model.sv
// Behavioural 16-bit erasable memory: command decoder, array and status reads.
// Assumes the host strobes the async pins; the shared data bus is resolved here.
`timescale 1ns/100ps
module nps_mem_model #(
   parameter        BUSY_READS = 3,       // Status reads before an algorithm ends
   parameter [15:0] MFR_CODE   = 16'h0000, // Arbitrary value
   parameter [15:0] DEV_CODE   = 16'h0000  // Arbitrary value
) (
   input  logic [20:0] addr,
   input  logic [15:0] hostData,
   input  logic        hostOe,
   input  logic        chipSel_n,
   input  logic        writeEn_n,
   input  logic        outEn_n,
   input  logic        reset_n,
   input  logic        accel,
   input  logic        failMode,
   output logic [15:0] busData
);
   logic [15:0] mem [int];          // Unwritten words read as erased
   logic [15:0] rdVal   = 16'h0000; // Word driven during a read
   logic [15:0] progVal = 16'h0000; // Word being programmed
   logic [20:0] wAddr   = 21'h0;    // Address latched by the write strobe
   int          st = 0;             // Command sequence step, 7 is identify mode
   int          busy = 0;           // Status reads left in the running algorithm
   logic        erasing = 0;
   logic        tog = 0;
   logic        tOut = 0;
   // A released bus shows the inverse so stale data cannot pass for a read
   assign busData = hostOe ? hostData : (!chipSel_n && !outEn_n) ? rdVal : ~rdVal;
   function logic [15:0] arr(input int a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction
   // Address is taken on the falling write strobe
   always @(negedge writeEn_n) if (!chipSel_n) wAddr = addr;
   // Data taken on the rising strobe; commands are ignored while busy, except reset after a timeout
   always @(posedge writeEn_n) if (!chipSel_n && reset_n) begin
      if (hostData == 16'h00f0 && (busy == 0 || tOut)) begin
         st = 0; busy = 0; tOut = 0;
      end else if (busy == 0) case (st)
         0: st = (wAddr == 21'h555 && hostData == 16'h00aa) ? 1 :
                 (accel && wAddr == 21'h555 && hostData == 16'h00a0) ? 3 : 0;
         1: st = (wAddr == 21'h2aa && hostData == 16'h0055) ? 2 : 0;
         2: st = wAddr != 21'h555 ? 0 : hostData == 16'h00a0 ? 3 :
                 hostData == 16'h0080 ? 4 : hostData == 16'h0090 ? 7 : 0;
         3: begin
            progVal = hostData; erasing = 0; busy = BUSY_READS; st = 0;
            if (!failMode) mem[wAddr] = arr(wAddr) & hostData;
         end
         4: st = (wAddr == 21'h555 && hostData == 16'h00aa) ? 5 : 0;
         5: st = (wAddr == 21'h2aa && hostData == 16'h0055) ? 6 : 0;
         6: if (wAddr == 21'h555 && hostData == 16'h0010) begin
            mem.delete(); erasing = 1; busy = BUSY_READS; st = 0;
         end else st = 0;
         default: ;
      endcase
   end
   // Status while busy, codes in identify mode, array otherwise
   always @(negedge outEn_n) if (!chipSel_n) begin
      if (busy > 0) begin
         tog = ~tog; tOut = failMode;
         // Poll bit is only the inverse at the address being programmed
         rdVal = {8'h00, erasing ? 1'b0 : (addr == wAddr) ? ~progVal[7] : progVal[7], tog, tOut, 5'h00};
         if (!failMode) busy = busy - 1; // A timed-out part never finishes
      end else if (st == 7) rdVal = (addr[6] | addr[1]) ? 16'h0000 : addr[0] ? DEV_CODE : MFR_CODE;
      else rdVal = arr(addr);
   end
   // Reset pin drops any algorithm and partial sequence
   always @(negedge reset_n) begin st = 0; busy = 0; tOut = 0; end
endmodule // nps_mem_model

// ### testbench/nps_host_sequencer_props.sv
// Checker for the host sequencer: pin discipline and command handshake.
// Sees only top-level ports; bound into every sequencer instance.
`timescale 1ns/100ps
module nps_host_sequencer_props (
   input logic        sys_clk,
   input logic        rst,
   input logic        cmdValid,
   input logic [2:0]  cmdOp,
   input logic        cmdReady,
   input logic        cmdDone,
   input logic        cmdFail,
   input logic [20:0] memAddr,
   input logic [15:0] memDataOut,
   input logic        memDataOe,
   input logic        memChipSel_n,
   input logic        memWriteEn_n,
   input logic        memOutEn_n,
   input logic        memReset_n,
   input logic        accelHigh
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   int   resetLow; // Cycles the reset pin has been low
   int   weLow;    // Cycles the write strobe has been low
   logic accelOk;  // Last accepted command was an accelerated program
   // Helper counters; cleared at reset so no stale count survives
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         resetLow <= 0; weLow <= 0; accelOk <= 1'b0;
      end else begin
         resetLow <= memReset_n ? 0 : resetLow + 1;
         weLow <= memWriteEn_n ? 0 : weLow + 1;
         if (cmdValid && cmdReady) accelOk <= (cmdOp == 3'h5);
      end
   end
   AST_TAKEN: assert property (cmdValid && cmdReady |=> !cmdReady) else $error("command not taken");
   AST_DONE_PULSE: assert property (cmdDone |=> !cmdDone ##[0:1] cmdReady) else $error("done not a pulse");
   AST_IDLE_QUIET: assert property (cmdReady |-> memChipSel_n && memWriteEn_n && memOutEn_n && !memDataOe)
      else $error("pins active in idle");
   AST_NO_CLASH: assert property (!memOutEn_n |-> !memDataOe && memWriteEn_n) else $error("bus clash");
   AST_WE_FRAMED: assert property (!memWriteEn_n |-> !memChipSel_n && memDataOe && memOutEn_n)
      else $error("write strobe unframed");
   AST_WE_STABLE: assert property (!memWriteEn_n && !$past(memWriteEn_n) |-> $stable(memAddr) && $stable(memDataOut))
      else $error("address or data moved");
   AST_WE_WIDTH: assert property ($rose(memWriteEn_n) |-> weLow inside {[13:14]}) else $error("strobe width");
   AST_RST_PULSE: assert property ($rose(memReset_n) |-> resetLow == 13) else $error("reset pulse width");
   AST_RST_QUIET: assert property (!memReset_n |-> memChipSel_n) else $error("cycle during reset");
   AST_ACCEL: assert property (accelHigh |-> accelOk && !cmdReady) else $error("accelerate pin misused");
   cover property (cmdDone && cmdFail);
   cover property (!memReset_n);
   cover property (accelHigh);
   cover property ($fell(memOutEn_n));
endmodule // nps_host_sequencer_props
bind nps_host_sequencer nps_host_sequencer_props u_props (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid),
   .cmdOp(cmdOp), .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdFail(cmdFail), .memAddr(memAddr),
   .memDataOut(memDataOut), .memDataOe(memDataOe), .memChipSel_n(memChipSel_n), .memWriteEn_n(memWriteEn_n),
   .memOutEn_n(memOutEn_n), .memReset_n(memReset_n), .accelHigh(accelHigh));

// ### testbench/nps_host_sequencer_tb.sv
// Self-checking bench: sequencer against the memory model and a reference array.
// Assumes the model resolves the shared data bus from both enables.
`timescale 1ns/100ps
module nps_host_sequencer_tb;
   localparam [15:0] MFR = 16'h1234; // Arbitrary value
   localparam [15:0] DEV = 16'h5678; // Arbitrary value
   logic        sys_clk = 0, rst = 1, cmdValid = 0, abortReq = 0, failMode = 0;
   logic [2:0]  cmdOp = 3'h0;
   logic [20:0] cmdAddr = 21'h0, a;
   logic [15:0] cmdData = 16'h0000, d;
   wire  [15:0] memDataIn, rdData, memDataOut;
   wire  [20:0] memAddr;
   wire         cmdReady, cmdDone, cmdFail, memDataOe, memChipSel_n, memWriteEn_n, memOutEn_n, memReset_n, accelHigh;
   int          n_errors = 0, check_count = 0;
   logic [15:0] refMem [int]; // Reference array; missing words are erased
   always #2.5 sys_clk = ~sys_clk;
   nps_host_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .abortReq(abortReq), .memDataIn(memDataIn), .cmdReady(cmdReady),
      .cmdDone(cmdDone), .cmdFail(cmdFail), .rdData(rdData), .memAddr(memAddr), .memDataOut(memDataOut),
      .memDataOe(memDataOe), .memChipSel_n(memChipSel_n), .memWriteEn_n(memWriteEn_n),
      .memOutEn_n(memOutEn_n), .memReset_n(memReset_n), .accelHigh(accelHigh));
   nps_mem_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_mem (.addr(memAddr), .hostData(memDataOut),
      .hostOe(memDataOe), .chipSel_n(memChipSel_n), .writeEn_n(memWriteEn_n), .outEn_n(memOutEn_n),
      .reset_n(memReset_n), .accel(accelHigh), .failMode(failMode), .busData(memDataIn));
   function logic [15:0] refRd(input [20:0] x);
      return refMem.exists(x) ? refMem[x] : 16'hffff;
   endfunction
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One command: wait for idle, request for one edge, bounded wait for done
   task op(input [2:0] o, input [20:0] x, input [15:0] y);
      int k;
      @(posedge sys_clk);
      for (k = 0; k < 100 && cmdReady !== 1'b1; k++) @(posedge sys_clk);
      cmdValid <= 1'b1; cmdOp <= o; cmdAddr <= x; cmdData <= y;
      @(posedge sys_clk);
      cmdValid <= 1'b0;
      for (k = 0; k < 40000 && cmdDone !== 1'b1; k++) @(posedge sys_clk);
      if (k == 40000) chk("done", 16'h0000, 16'h0001);
   endtask
   // Program, then read back; fail flag expected when poll bit 7 could not rise from 0
   task prog(input [2:0] o, input [20:0] x, input [15:0] y);
      op(o, x, y);
      refMem[x] = refRd(x) & y;
      chk("progfail", {15'h0, cmdFail}, {15'h0, refMem[x][7] !== y[7]});
      op(3'h0, x, 16'h0000);
      chk("progread", rdData, refMem[x]);
   endtask
   task conclude;
      $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Hang guard, well beyond the expected run length
   initial begin
      #400000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      void'($urandom(76915));
      a = 21'h1000 + $urandom % 21'h1000;
      op(3'h0, a, 16'h0000);
      chk("powerup", rdData, 16'hffff);
      $display("Test powerup done");
      repeat (3) begin
         a = 21'h1000 + $urandom % 21'h1000;
         d = $urandom & 16'hff7f; // Poll bit left cleared for the raise attempt
         prog(3'h1, a, d);
      end
      prog(3'h1, a, $urandom | 16'h0080); // Tries to raise a cleared poll bit
      prog(3'h5, a + 21'h1, $urandom);
      $display("Test program done");
      op(3'h3, 21'h0, 16'h0000);
      chk("maker", rdData, MFR);
      op(3'h3, 21'h1, 16'h0000);
      chk("device", rdData, DEV);
      op(3'h4, 21'h0, 16'h0000);
      op(3'h0, a, 16'h0000);
      chk("idexit", rdData, refMem[a]);
      $display("Test identify done");
      op(3'h2, 21'h0, 16'h0000);
      refMem.delete();
      chk("erasefail", {15'h0, cmdFail}, 16'h0000);
      op(3'h0, a, 16'h0000);
      chk("erased", rdData, 16'hffff);
      $display("Test erase done");
      failMode <= 1'b1;
      op(3'h1, a, $urandom);
      chk("timeout", {15'h0, cmdFail}, 16'h0001);
      failMode <= 1'b0;
      op(3'h0, a, 16'h0000);
      chk("aftertimeout", rdData, 16'hffff);
      $display("Test timeout done");
      repeat (4) @(posedge sys_clk);
      abortReq <= 1'b1;
      @(posedge sys_clk);
      abortReq <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("resetpin", {15'h0, memReset_n}, 16'h0000);
      repeat (18) @(posedge sys_clk);
      chk("resetrel", {15'h0, memReset_n}, 16'h0001);
      // An erase request in mid-program must be ignored, so data survives
      fork
         prog(3'h1, a, $urandom);
         begin
            repeat (150) @(posedge sys_clk);
            cmdValid <= 1'b1; cmdOp <= 3'h2;
            @(posedge sys_clk);
            cmdValid <= 1'b0;
         end
      join
      $display("Test abort and refusal done");
      conclude();
   end
endmodule // nps_host_sequencer_tb
